// [fpic_top.sv]
`timescale 1ns/1ps
`include "fpic_defines.svh"
module fpic_top #(
  parameter fpic_pkg::fpic_cnt_t DEB_CYC   = 32'(`FPIC_DEBOUNCE_MS * `FPIC_CLK_KHZ),
  parameter fpic_pkg::fpic_cnt_t PHASE_CYC = 32'(`FPIC_PHASE_MS * `FPIC_CLK_KHZ),
  parameter fpic_pkg::fpic_cnt_t HOLD_CYC  = 32'(`FPIC_HOLD_MS * `FPIC_CLK_KHZ),
  parameter fpic_pkg::fpic_cnt_t DUMP_CYC  = 32'(`FPIC_DUMP_MS * `FPIC_CLK_KHZ)
) (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                resetn_in,
  // AHB-Lite slave
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  output logic [31:0]              hrdata_out,
  output logic                     hreadyout_out,
  output logic                     hresp_out,
  // Operator panel
  input  wire fpic_pkg::fpic_btn_s buttons_n_in,
  output fpic_pkg::fpic_led_s      led_out,
  output logic                     buzzer_out,
  // System power and reset control
  input  wire logic                power_on_in,
  output logic                     power_toggle_out,
  output logic                     sys_reset_out,
  output logic                     reg_dump_req_out,
  output logic                     clear_settings_out,
  output logic                     boot_bank_out
);
  import fpic_pkg::*;

  fpic_state_s st_r;
  fpic_state_s st_nxt;
  logic [1:0]  hold_fire;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        ack;
  logic        wr_ctl;
  logic        wr_fault;
  fpic_ctrl_s  wctl;

  ////////////////////////////////////////////////////////////////////////////////
  // Fault indicator drive: steady for critical, slow blink for minor
  function automatic logic fault_led(input logic crit, input logic minor, input logic blink);
    fault_led = crit | (minor & blink);
  endfunction : fault_led

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic          blink;
    fpic_status_s  stat;
    logic [2:0]    crit_old;
    logic [2:0]    crit_new;
    logic [3:0]    btn;
    st_nxt    = st_r;
    blink     = ~st_r.phase[0];
    stat      = '0;
    crit_old  = '0;
    crit_new  = '0;
    btn       = buttons_n_in;
    hold_fire = '0;
    tick      = 1'b0;
    ack       = 1'b0;
    wctl      = fpic_ctrl_s'(hwdata_in);
    st_nxt.press     = '0;
    st_nxt.rst_pulse = 1'b0;
    st_nxt.pwr_tog   = 1'b0;
    // Two-flop sync then stability filter per button
    for (int i = 0; i < 4; i++) begin
      st_nxt.s1[i] = ~btn[i];
      st_nxt.s2[i] = st_r.s1[i];
      if (st_r.s2[i] == st_r.stable[i]) begin
        st_nxt.deb[i] = '0;
      end else if (st_r.deb[i] == DEB_CYC - 32'h1) begin
        st_nxt.deb[i]    = '0;
        st_nxt.stable[i] = st_r.s2[i];
        st_nxt.press[i]  = st_r.s2[i];
      end else begin
        st_nxt.deb[i] = st_r.deb[i] + 32'h1;
      end
    end
    // Hold timers for reset and diagnostic buttons, restart on release
    for (int k = 0; k < 2; k++) begin
      if (!st_r.stable[(k == `FPIC_HOLD_RST) ? `FPIC_BTN_RST : `FPIC_BTN_DIAG]) begin
        st_nxt.hold[k]  = '0;
        st_nxt.fired[k] = 1'b0;
      end else if (!st_r.fired[k]) begin
        if (st_r.hold[k] == HOLD_CYC - 32'h1) begin
          st_nxt.fired[k] = 1'b1;
          hold_fire[k]    = 1'b1;
        end else begin
          st_nxt.hold[k] = st_r.hold[k] + 32'h1;
        end
      end
    end
    // System power edges
    rise       = power_on_in & ~st_r.pon;
    fall       = ~power_on_in & st_r.pon;
    st_nxt.pon = power_on_in;
    // Blink phase base, 0.6 s per phase
    if (st_r.tick_cnt == PHASE_CYC - 32'h1) begin
      st_nxt.tick_cnt = '0;
      st_nxt.phase    = st_r.phase + 2'h1;
      tick            = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
    end
    // Bus data phase decode
    wr_ctl   = st_r.dp_sel & st_r.dp_wr & (st_r.dp_addr == `FPIC_ADDR_CTRL);
    wr_fault = st_r.dp_sel & st_r.dp_wr & (st_r.dp_addr == `FPIC_ADDR_FAULT);
    // Identify button: acknowledge a sounding buzzer, else toggle
    if (st_r.press[`FPIC_BTN_ID]) begin
      if (st_r.buzz) begin
        ack = 1'b1;
      end else begin
        st_nxt.id_on = ~st_nxt.id_on;
      end
    end
    if (wr_ctl && wctl.id_toggle) begin
      st_nxt.id_on = ~st_nxt.id_on;
    end
    // Fault latches: hardware clears first, software writes win
    crit_old = {st_r.fault.pwr_crit, st_r.fault.cool_crit, st_r.fault.gen_crit};
    if (rise || st_r.rst_pulse) begin
      st_nxt.fault.cool_crit  = 1'b0;
      st_nxt.fault.cool_minor = 1'b0;
      st_nxt.fault.gen_crit   = 1'b0;
      st_nxt.fault.gen_minor  = 1'b0;
    end
    if (ack) begin
      st_nxt.buzz            = 1'b0;
      st_nxt.fault.pwr_crit  = 1'b0;
      st_nxt.fault.cool_crit = 1'b0;
      st_nxt.fault.gen_crit  = 1'b0;
    end
    if (wr_fault) begin
      st_nxt.fault      = fpic_fault_s'(hwdata_in);
      st_nxt.fault.rsvd = '0;
    end
    crit_new = {st_nxt.fault.pwr_crit, st_nxt.fault.cool_crit, st_nxt.fault.gen_crit};
    if ((crit_new & ~crit_old) != 3'h0) begin
      st_nxt.buzz = 1'b1;
    end
    // Control register
    if (wr_ctl) begin
      st_nxt.ctl           = wctl;
      st_nxt.ctl.rsvd      = '0;
      st_nxt.ctl.id_toggle = 1'b0;
      st_nxt.ctl.dump_done = 1'b0;
    end
    // Power button and power-down tracking
    if (st_r.press[`FPIC_BTN_PWR]) begin
      st_nxt.pwr_tog = 1'b1;
    end
    if (!power_on_in) begin
      st_nxt.pwr_down = 1'b0;
    end else if (st_r.press[`FPIC_BTN_PWR]) begin
      st_nxt.pwr_down = 1'b1;
    end
    // Reset button while on: request dump, reset on done or timeout
    if (!power_on_in) begin
      st_nxt.dump_pend = 1'b0;
    end else if (st_r.dump_pend) begin
      if ((wr_ctl && wctl.dump_done) || st_r.dump_cnt == DUMP_CYC - 32'h1) begin
        st_nxt.dump_pend = 1'b0;
        st_nxt.rst_pulse = 1'b1;
      end else begin
        st_nxt.dump_cnt = st_r.dump_cnt + 32'h1;
      end
    end else if (st_r.press[`FPIC_BTN_RST]) begin
      st_nxt.dump_pend = 1'b1;
      st_nxt.dump_cnt  = '0;
    end
    // Diagnostic button while on resets at once
    if (power_on_in && st_r.press[`FPIC_BTN_DIAG]) begin
      st_nxt.rst_pulse = 1'b1;
    end
    // Recovery mode machine; the active mode ignores the other request
    case (st_r.mode)
      FPIC_MD_IDLE: begin
        if (!power_on_in && hold_fire[`FPIC_HOLD_RST]) begin
          st_nxt.mode = FPIC_MD_CLR;
        end else if (!power_on_in && hold_fire[`FPIC_HOLD_DIAG]) begin
          st_nxt.mode = FPIC_MD_EMRG;
        end
      end
      FPIC_MD_CLR: begin
        if (rise) begin
          st_nxt.mode    = FPIC_MD_IDLE;
          st_nxt.clr_set = 1'b1;
        end else if (st_r.press[`FPIC_BTN_RST]) begin
          st_nxt.mode = FPIC_MD_IDLE;
        end
      end
      FPIC_MD_EMRG: begin
        if (rise) begin
          st_nxt.mode = FPIC_MD_IDLE;
          st_nxt.bank = 1'b1;
        end else if (st_r.press[`FPIC_BTN_DIAG]) begin
          st_nxt.mode = FPIC_MD_IDLE;
        end
      end
      default: begin
        st_nxt.mode = FPIC_MD_IDLE;
      end
    endcase
    if (fall) begin
      st_nxt.clr_set = 1'b0;
      st_nxt.bank    = 1'b0;
    end
    // Lamp test at the first power-on after reset
    if (rise && !st_r.lamp_done) begin
      st_nxt.lamp_done = 1'b1;
      st_nxt.lamp_cnt  = `FPIC_LAMP_PHASES;
    end else if (tick && st_r.lamp_cnt != 3'h0) begin
      st_nxt.lamp_cnt = st_r.lamp_cnt - 3'h1;
    end
    // Indicator drive, highest priority last
    st_nxt.led.pwr    = st_r.pwr_down ? blink : power_on_in;
    st_nxt.led.pfault = fault_led(st_r.fault.pwr_crit, st_r.fault.pwr_minor, blink);
    st_nxt.led.cool   = fault_led(st_r.fault.cool_crit, st_r.fault.cool_minor, blink);
    st_nxt.led.gfault = fault_led(st_r.fault.gen_crit, st_r.fault.gen_minor, blink);
    if (st_r.mode == FPIC_MD_CLR) begin
      st_nxt.led.id = (st_r.phase != `FPIC_PH_LAST);
    end else if (st_r.mode == FPIC_MD_EMRG) begin
      st_nxt.led.id = (st_r.phase == `FPIC_PH_FIRST);
    end else if (st_r.ctl.recov) begin
      st_nxt.led.id = blink;
    end else begin
      st_nxt.led.id = st_r.id_on;
    end
    st_nxt.buzzer = st_r.buzz;
    if (st_r.ctl.test) begin
      st_nxt.led.pfault = 1'b1;
      st_nxt.led.cool   = 1'b1;
      st_nxt.led.gfault = 1'b1;
      st_nxt.buzzer     = 1'b1;
    end
    if (st_r.lamp_cnt != 3'h0) begin
      st_nxt.led = '1;
    end
    if (st_r.ctl.copy) begin
      st_nxt.led = {5{blink}};
    end
    if (st_r.ctl.damage) begin
      st_nxt.led    = '1;
      st_nxt.buzzer = 1'b1;
    end
    // Address phase capture and read data
    st_nxt.dp_sel  = hsel_in & hready_in & (htrans_in == `FPIC_HTRANS_NONSEQ)
                     & (hsize_in == `FPIC_HSIZE_WORD) & (haddr_in[31:8] == `FPIC_ADDR_HI_ZERO);
    st_nxt.dp_wr   = hwrite_in;
    st_nxt.dp_addr = haddr_in[7:0];
    stat = '{rsvd: '0, lamp: (st_r.lamp_cnt != 3'h0), dump_pend: st_r.dump_pend,
             id_on: st_r.id_on, buzz: st_r.buzz, bank: st_r.bank, clr_set: st_r.clr_set,
             emrg: (st_r.mode == FPIC_MD_EMRG), clr: (st_r.mode == FPIC_MD_CLR),
             pwr_down: st_r.pwr_down, pwr_on: st_r.pon};
    st_nxt.rdata = '0;
    if (st_nxt.dp_sel && !hwrite_in) begin
      case (haddr_in[7:0])
        `FPIC_ADDR_CTRL:   st_nxt.rdata = st_r.ctl;
        `FPIC_ADDR_FAULT:  st_nxt.rdata = st_r.fault;
        `FPIC_ADDR_STATUS: st_nxt.rdata = stat;
        default:           st_nxt.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; synchronous active-low reset
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_r      <= '0;
      st_r.mode <= FPIC_MD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata_out         = st_r.rdata;
  assign hreadyout_out      = 1'b1; // Zero wait states
  assign hresp_out          = 1'b0; // Always OKAY
  assign led_out            = st_r.led;
  assign buzzer_out         = st_r.buzzer;
  assign power_toggle_out   = st_r.pwr_tog;
  assign sys_reset_out      = st_r.rst_pulse;
  assign reg_dump_req_out   = st_r.dump_pend;
  assign clear_settings_out = st_r.clr_set;
  assign boot_bank_out      = st_r.bank;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_emrg_power_on;
    st_r.mode == FPIC_MD_EMRG && power_on_in && !st_r.pon;
  endsequence
  sequence s_bank_driven;
    st_r.bank ##1 boot_bank_out;
  endsequence

  // Indicator drive from the power state and the fault latches
  a_pwr_led_on: assert property (
    (power_on_in && !st_r.pwr_down && !st_r.ctl.copy) |=> led_out.pwr)
    else $error("power LED dark while on");
  a_pfault_steady: assert property (
    (st_r.fault.pwr_crit && !st_r.ctl.copy) |=> led_out.pfault)
    else $error("power fault LED not steady");
  a_cool_steady: assert property (
    (st_r.fault.cool_crit && !st_r.ctl.copy) |=> led_out.cool)
    else $error("cooling fault LED not steady");
  a_gen_steady: assert property (
    (st_r.fault.gen_crit && !st_r.ctl.copy) |=> led_out.gfault)
    else $error("general fault LED not steady");

  // Fault clearing and acknowledge; a remote toggle in the same cycle is legal
  a_cool_clear: assert property (
    (rise && !wr_fault) |=> !st_r.fault.cool_crit && !st_r.fault.cool_minor)
    else $error("cooling fault kept at power-on");
  a_buzz_ack: assert property (
    (ack && !wr_fault && !(wr_ctl && wctl.id_toggle))
    |=> !st_r.buzz && st_r.id_on == $past(st_r.id_on) && !st_r.fault.gen_crit)
    else $error("acknowledge failed");

  // Identify toggling
  a_id_toggle: assert property (
    (st_r.press[`FPIC_BTN_ID] && !st_r.buzz && !(wr_ctl && wctl.id_toggle))
    |=> st_r.id_on != $past(st_r.id_on))
    else $error("identify press did not toggle");

  // Recovery modes; the clear-mode LED is dark only in the last phase
  a_clr_enter: assert property (
    (st_r.mode == FPIC_MD_IDLE && !power_on_in && hold_fire[`FPIC_HOLD_RST])
    |=> st_r.mode == FPIC_MD_CLR
    ##1 (led_out.id || $past(st_r.ctl.copy) || $past(st_r.phase) == `FPIC_PH_LAST))
    else $error("settings-clear not entered");
  a_clr_cancel: assert property (
    (st_r.mode == FPIC_MD_CLR && st_r.press[`FPIC_BTN_RST] && !rise)
    |=> st_r.mode == FPIC_MD_IDLE && !clear_settings_out)
    else $error("settings-clear not cancelled");
  a_emrg_enter: assert property (
    (st_r.mode == FPIC_MD_IDLE && !power_on_in && hold_fire[`FPIC_HOLD_DIAG]
     && !hold_fire[`FPIC_HOLD_RST]) |=> st_r.mode == FPIC_MD_EMRG)
    else $error("emergency mode not entered");
  a_emrg_bank: assert property (s_emrg_power_on |=> s_bank_driven)
    else $error("boot bank not switched");
  a_mode_excl: assert property (
    (st_r.mode == FPIC_MD_CLR && hold_fire[`FPIC_HOLD_DIAG]) |=> st_r.mode != FPIC_MD_EMRG)
    else $error("second recovery mode entered");

  // Resets while powered on; the dump wait ends in a reset at its last count
  a_diag_reset: assert property (
    (power_on_in && st_r.press[`FPIC_BTN_DIAG]) |=> sys_reset_out)
    else $error("diagnostic press gave no reset");
  a_dump_bound: assert property (
    (power_on_in && st_r.dump_pend && st_r.dump_cnt == DUMP_CYC - 32'h1)
    |=> sys_reset_out && !reg_dump_req_out)
    else $error("dump wait overran");

  // Panel tests and controller firmware modes
  a_lamp_all: assert property (
    (rise && !st_r.lamp_done && !st_r.ctl.copy && !wr_ctl) |=> ##1 led_out == 5'h1F)
    else $error("lamp test missing");
  a_test_drive: assert property (
    (st_r.ctl.test && !st_r.ctl.copy)
    |=> led_out.pfault && led_out.cool && led_out.gfault && buzzer_out)
    else $error("test command not shown");
  a_damage_all: assert property (
    st_r.ctl.damage |=> led_out == 5'h1F && buzzer_out)
    else $error("damage indication missing");
endmodule : fpic_top

// [fpic_defines.svh]
`ifndef FPIC_DEFINES_SVH
`define FPIC_DEFINES_SVH
// Summary of operation
// - Power LED on; blinks 1.2 s while powering off
// - Power fault LED: steady critical, blink minor
// - Power fault kept at power-on and reset, cleared at controller reset
// - Cooling fault LED: steady critical, blink minor
// - Cooling fault clears at power-on or reset
// - General fault LED: steady critical, blink minor
// - General fault clears at power-on or reset
// - Identify press or remote command toggles ID LED
// - Identify press silences buzzer, ID LED unchanged
// - Critical fault sounds buzzer; acknowledge clears both
// - Reset press powered on: dump, reset within 15 s
// - Reset held 10 s off: settings-clear mode
// - Reset press cancels; power-on flags settings clear
// - Diagnostic press powered on issues a reset
// - Diagnostic held 10 s off: emergency boot mode
// - Emergency mode power-on selects boot bank 1
// - Firmware recovery command blinks ID 0.6/0.6 s
// - Recovery modes exclusive; first entered keeps priority
// - All LEDs lit at first power-on lamp test
// - Test command drives buzzer and fault LEDs
// - Firmware copy blinks all LEDs
// - Firmware damage lights all LEDs plus buzzer
////////////////////////////////////////////////////////////////////////////////
// Timing, in milliseconds and kHz, lamp test length in blink phases
`define FPIC_CLK_KHZ       64'd125000
`define FPIC_DEBOUNCE_MS   64'd10
`define FPIC_PHASE_MS      64'd600
`define FPIC_HOLD_MS       64'd10000
`define FPIC_DUMP_MS       64'd15000
`define FPIC_LAMP_PHASES   3'h4
// Blink phase holding the off slot of the settings-clear pattern
`define FPIC_PH_LAST       2'h3
`define FPIC_PH_FIRST      2'h0
// Register byte offsets
`define FPIC_ADDR_CTRL     8'h00
`define FPIC_ADDR_FAULT    8'h04
`define FPIC_ADDR_STATUS   8'h08
`define FPIC_ADDR_HI_ZERO  24'h000000
// Bus encodings
`define FPIC_HTRANS_NONSEQ 2'h2
`define FPIC_HSIZE_WORD    3'h2
// Button indices inside the button struct
`define FPIC_BTN_ID        0
`define FPIC_BTN_DIAG      1
`define FPIC_BTN_RST       2
`define FPIC_BTN_PWR       3
`define FPIC_HOLD_RST      0
`define FPIC_HOLD_DIAG     1
`endif

// [fpic_pkg.sv]
package fpic_pkg;
  typedef logic [31:0] fpic_cnt_t;
  typedef enum logic [2:0] {
    FPIC_MD_IDLE = 3'b001,
    FPIC_MD_CLR  = 3'b010,
    FPIC_MD_EMRG = 3'b100
  } fpic_mode_e;
  // Buttons, active low at the pins
  typedef struct packed {logic pwr; logic rst; logic diag; logic id;} fpic_btn_s;
  typedef struct packed {logic pwr; logic cool; logic pfault; logic gfault; logic id;} fpic_led_s;
  typedef struct packed {
    logic [25:0] rsvd;
    logic dump_done; logic id_toggle; logic recov; logic test; logic damage; logic copy;
  } fpic_ctrl_s;
  typedef struct packed {
    logic [25:0] rsvd;
    logic gen_minor; logic gen_crit; logic cool_minor; logic cool_crit;
    logic pwr_minor; logic pwr_crit;
  } fpic_fault_s;
  typedef struct packed {
    logic [21:0] rsvd;
    logic lamp; logic dump_pend; logic id_on; logic buzz; logic bank;
    logic clr_set; logic emrg; logic clr; logic pwr_down; logic pwr_on;
  } fpic_status_s;
  typedef struct packed {
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      stable;
    logic [3:0]      press;
    fpic_cnt_t [3:0] deb;
    fpic_cnt_t [1:0] hold;
    logic [1:0]      fired;
    fpic_cnt_t       tick_cnt;
    logic [1:0]      phase;
    logic [2:0]      lamp_cnt;
    logic            lamp_done;
    logic            pon;
    logic            pwr_down;
    fpic_mode_e      mode;
    logic            clr_set;
    logic            bank;
    fpic_ctrl_s      ctl;
    fpic_fault_s     fault;
    logic            buzz;
    logic            id_on;
    logic            dump_pend;
    fpic_cnt_t       dump_cnt;
    logic            rst_pulse;
    logic            pwr_tog;
    fpic_led_s       led;
    logic            buzzer;
    logic [31:0]     rdata;
    logic            dp_sel;
    logic            dp_wr;
    logic [7:0]      dp_addr;
  } fpic_state_s;
endpackage : fpic_pkg

// [fpic_sys_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of the panel: system power rail and platform firmware
module fpic_sys_model #(
  parameter int ON_DLY  = 3,
  parameter int OFF_DLY = 60
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  // Requests from the panel logic
  input  wire logic power_toggle_in,
  input  wire logic clear_settings_in,
  // System state seen by the panel logic
  output logic      power_on_out,
  output logic      settings_cleared_out
);
  int cnt_r;

  // Rail follows a toggle after a settling delay, ignoring toggles while settling; off is slow to show blinking
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      power_on_out <= 1'b0;
      cnt_r        <= 0;
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
    end else if (cnt_r == 1) begin
      cnt_r        <= 0;
      power_on_out <= !power_on_out;
    end else if (power_toggle_in) begin
      cnt_r <= power_on_out ? OFF_DLY : ON_DLY;
    end
  end

  // Firmware wipes stored settings when booted with the clear flag up
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      settings_cleared_out <= 1'b0;
    end else if (power_on_out && clear_settings_in) begin
      settings_cleared_out <= 1'b1;
    end
  end
endmodule : fpic_sys_model

// [front_panel_indicator_control_tb.sv]
`timescale 1ns/1ps
`include "fpic_defines.svh"
module front_panel_indicator_control_tb;
  import fpic_pkg::*;
  localparam int DEB  = 4;
  localparam int PH   = 8;
  localparam int HOLD = 50;
  localparam int DUMP = 40;
  localparam int TAP  = 10;
  localparam int LONG = 64;
  logic        clk, rstn, hsel, hwrite, pon, hrdy, hresp;
  logic        ptog, sysrst, dump, clrs, bank, buzz, wiped;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  btn_n;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  fpic_led_s   led;
  int          miscompares, cmp_count, m_fault, m_buzz, m_id;
  wire  [5:0]  obs = {buzz, led};
  wire  [3:0]  ev  = {hrdy, !pon, sysrst, pon};

  ////////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  fpic_top #(.DEB_CYC(DEB), .PHASE_CYC(PH), .HOLD_CYC(HOLD), .DUMP_CYC(DUMP)) fpic_top_inst (
    .core_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .buttons_n_in(btn_n), .led_out(led), .buzzer_out(buzz), .power_on_in(pon),
    .power_toggle_out(ptog), .sys_reset_out(sysrst), .reg_dump_req_out(dump),
    .clear_settings_out(clrs), .boot_bank_out(bank));
  fpic_sys_model #(.ON_DLY(3), .OFF_DLY(60)) fpic_sys_model_inst (
    .core_clk_in(clk), .resetn_in(rstn), .power_toggle_in(ptog),
    .clear_settings_in(clrs), .power_on_out(pon), .settings_cleared_out(wiped));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s: got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Bounded wait for one observed event; running out ends the run
  task waitp(input int s, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ev[s] !== 1'b1 && k < lim);
    if (k >= lim) begin
      miscompares++;
      $display("[ERR] %0t wait %0d timed out", $time, s);
      stop_test();
    end
  endtask : waitp

  // One AHB single transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= `FPIC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= `FPIC_HSIZE_WORD;
    waitp(3, 20);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    waitp(3, 20);
    rd = hrdata;
  endtask : bus

  // Write with the reference model following along
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == `FPIC_ADDR_FAULT) begin
      m_buzz |= int'((d & ~m_fault & 32'h15) != 0);
      m_fault = d & 32'h3F;
    end
    if (a == `FPIC_ADDR_CTRL && d[4]) m_id ^= 1;
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e, input string m);
    cyc(1);
    bus(1'b0, a, 32'h0);
    chk(rd & mk, e, m);
  endtask : rdc

  // Press a button for k cycles, or until event s when s is not negative
  task press(input int i, input int k, input int s);
    btn_n[i] <= 1'b0;
    if (s >= 0) waitp(s, k);
    else cyc(k);
    btn_n[i] <= 1'b1;
    cyc(DEB + 8);
    if (i == `FPIC_BTN_ID && m_buzz == 1) begin
      m_buzz = 0;
      m_fault = m_fault & 32'h2A;
    end else if (i == `FPIC_BTN_ID) begin
      m_id ^= 1;
    end
  endtask : press

  // Count lit cycles of one output over a whole four-phase period
  task blink(input int s, input int e, input string m);
    int h;
    h = 0;
    repeat (4 * PH) begin
      @(posedge clk);
      h += int'(obs[s] === 1'b1);
    end
    chk(32'(h), 32'(e), m);
  endtask : blink

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Main sequence
  initial begin
    {rstn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    btn_n = 4'hF;
    seed  = 32'h1F88;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(32'({obs, dump, clrs, bank, hresp}), 32'h0, "reset outputs");
    seed = lfsr(seed);
    wr(`FPIC_ADDR_FAULT, seed & 32'h2A);
    rdc(`FPIC_ADDR_FAULT, 32'hFFFFFFFF, m_fault, "fault readback");
    seed = lfsr(seed);
    wr(`FPIC_ADDR_STATUS, seed);
    rdc(`FPIC_ADDR_STATUS, 32'hFFFFFFFF, 32'h0, "status read-only");
    wr(8'h0C, seed);
    rdc(8'h0C, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test done: registers");
    // Fault indicators, buzzer and identify
    wr(`FPIC_ADDR_FAULT, 32'h2A);
    cyc(3);
    blink(3, 16, "cool minor");
    blink(2, 16, "power minor");
    blink(1, 16, "general minor");
    wr(`FPIC_ADDR_FAULT, 32'h15);
    cyc(3);
    blink(3, 32, "cool steady");
    chk(32'(obs) & 32'h2E, 32'h2E, "critical with buzzer");
    press(`FPIC_BTN_ID, TAP, -1);
    chk(32'({buzz, led.id}), 32'({m_buzz[0], m_id[0]}), "silence");
    rdc(`FPIC_ADDR_FAULT, 32'hFFFFFFFF, m_fault, "acknowledge");
    press(`FPIC_BTN_ID, TAP, -1);
    chk(32'(led.id), 32'(m_id[0]), "id press");
    wr(`FPIC_ADDR_CTRL, 32'h10);
    cyc(3);
    chk(32'(led.id), 32'(m_id[0]), "remote id");
    $display("test done: faults");
    // Recovery modes while powered off
    press(`FPIC_BTN_RST, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h04, "clear mode");
    blink(0, 24, "clear blink");
    press(`FPIC_BTN_DIAG, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h04, "first mode kept");
    press(`FPIC_BTN_RST, TAP, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h00, "clear cancelled");
    press(`FPIC_BTN_DIAG, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h08, "emergency mode");
    blink(0, 8, "emergency blink");
    press(`FPIC_BTN_DIAG, TAP, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h00, "emergency cancelled");
    press(`FPIC_BTN_DIAG, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h08, "emergency re-entered");
    press(`FPIC_BTN_RST, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h08, "second mode ignored");
    $display("test done: modes");
    // First power-on
    wr(`FPIC_ADDR_FAULT, 32'h05);
    press(`FPIC_BTN_PWR, 40, 0);
    m_fault = m_fault & 32'h03;
    chk(32'(led), 32'h1F, "lamp test");
    chk(32'(bank), 32'h1, "emergency bank");
    rdc(`FPIC_ADDR_FAULT, 32'hFFFFFFFF, m_fault, "power-on clear");
    cyc(40);
    chk(32'(led.pwr), 32'h1, "power led on");
    $display("test done: power-on");
    // Resets while powered on
    wr(`FPIC_ADDR_FAULT, 32'h11);
    press(`FPIC_BTN_RST, TAP, -1);
    chk(32'(dump), 32'h1, "dump request");
    wr(`FPIC_ADDR_CTRL, 32'h20);
    waitp(1, 10);
    m_fault = m_fault & 32'h03;
    cyc(1);
    chk(32'(dump), 32'h0, "dump released");
    rdc(`FPIC_ADDR_FAULT, 32'hFFFFFFFF, m_fault, "reset clear");
    press(`FPIC_BTN_RST, TAP, -1);
    waitp(1, DUMP + 20);
    press(`FPIC_BTN_DIAG, 30, 1);
    $display("test done: resets");
    // Controller commands, one bit at a time
    for (int i = 0; i < 4; i++) begin
      wr(`FPIC_ADDR_CTRL, 32'h1 << i);
      cyc(3);
      case (i)
        0: for (int s = 0; s < 5; s++) blink(s, 16, "copy blink");
        1: chk(32'(obs), 32'h3F, "damage");
        2: chk(32'(obs) & 32'h2E, 32'h2E, "test command");
        default: blink(0, 16, "recovery blink");
      endcase
    end
    wr(`FPIC_ADDR_CTRL, 32'h0);
    $display("test done: commands");
    // Power-off, then boot with settings clear armed
    press(`FPIC_BTN_PWR, TAP, -1);
    blink(4, 16, "power-down blink");
    waitp(2, 80);
    cyc(3);
    chk(32'(led.pwr), 32'h0, "power led off");
    press(`FPIC_BTN_RST, LONG, -1);
    rdc(`FPIC_ADDR_STATUS, 32'h0C, 32'h04, "clear armed");
    press(`FPIC_BTN_PWR, 40, 0);
    chk(32'({clrs, wiped, bank}), 32'h6, "settings clear boot");
    $display("test done: settings clear");
    stop_test();
  end
endmodule : front_panel_indicator_control_tb
